// *** core/rmha_link.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmha_link
  import rmha_pkg::*;
#(
  parameter int BOOT_SAMPLE = BOOT_CYC,
  parameter int PCM_HALF    = PCM_HALF_DEF,
  parameter int PCM_W       = PCM_WORD,
  parameter int SLOTS       = PCM_SLOTS,
  parameter int UART_DIV    = BAUD_DIV
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_wifi_function_enable,
  input  wire logic             i_bluetooth_enable,
  input  wire rmha_strap_type   i_strap_level,
  output logic                  o_wifi_active,
  output logic                  o_bt_active,
  output logic                  o_fault,
  output logic                  o_straps_latched,
  output rmha_strap_type        o_strap_value,
  input  wire logic             i_pcm_master,
  input  wire logic             i_pcm_clk,
  output logic                  o_pcm_clk,
  output logic                  o_pcm_clk_oe,
  input  wire logic             i_pcm_sync,
  output logic                  o_pcm_sync,
  output logic                  o_pcm_sync_oe,
  input  wire logic             i_pcm_din,
  output logic                  o_pcm_dout,
  output logic                  o_pcm_dout_oe,
  input  wire logic [PCM_W-1:0] i_pcm_tx_word,
  output logic                  o_pcm_tx_take,
  output logic [PCM_W-1:0]      o_pcm_rx_word,
  output logic                  o_pcm_rx_valid,
  input  wire logic [7:0]       i_hci_tx_data,
  input  wire logic             i_hci_tx_valid,
  output logic                  o_hci_tx_ready,
  output rmha_byte_type         o_hci_rx,
  input  wire logic             i_hci_rx_hold,
  output logic                  o_hci_serial_tx,
  output logic                  o_hci_serial_tx_oe,
  input  wire logic             i_hci_serial_rx,
  output logic                  o_hci_request_to_send_n,
  output logic                  o_hci_request_to_send_oe,
  input  wire logic             i_hci_clear_to_send_n,
  input  wire logic [7:0]       i_coex_tx_data,
  input  wire logic             i_coex_tx_valid,
  output logic                  o_coex_tx_ready,
  output rmha_byte_type         o_coex_rx,
  output logic                  o_coexist_serial_tx,
  output logic                  o_coexist_serial_tx_oe,
  input  wire logic             i_coexist_serial_rx,
  input  wire logic             i_wake_request,
  output logic                  o_host_wakeup_out,
  output logic                  o_host_wakeup_out_oe,
  input  wire logic             i_low_power_clock_in,
  input  wire logic             i_use_ext_sleep_clk,
  input  wire logic             i_sleep_mode,
  output logic                  o_sleep_tick
);
  localparam int SW = $clog2(SLOTS);
  localparam int NS = 15;

  // two-stage synchroniser for every pin input
  logic [NS-1:0] meta;
  logic [NS-1:0] sy;
  always_ff @(posedge i_clock) begin
    meta <= {i_wifi_function_enable, i_bluetooth_enable, i_strap_level,
             i_pcm_clk, i_pcm_sync, i_pcm_din, i_hci_serial_rx,
             i_hci_clear_to_send_n, i_coexist_serial_rx,
             i_low_power_clock_in};
    sy   <= meta;
  end

  logic           wifi_s, bt_s, pclk_s, psync_s, din_s;
  logic           hrx_s, cts_n_s, crx_s, lpclk_s;
  rmha_strap_type strap_s;
  assign {wifi_s, bt_s, strap_s, pclk_s, psync_s, din_s, hrx_s,
          cts_n_s, crx_s, lpclk_s} = sy;

  // boot sequencing
  rmha_boot_type state;
  logic [31:0]   bcnt;
  logic          run;
  assign run = (state == BOOT_RUN);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state            <= BOOT_IDLE;
      bcnt             <= 32'h0;
      o_strap_value    <= STRAP_RESET;
      o_straps_latched <= 1'b0;
    end else begin
      case (state)
        BOOT_IDLE: begin
          bcnt <= 32'h0;
          if (wifi_s || bt_s) begin
            state <= BOOT_WAIT;
          end
        end
        BOOT_WAIT: begin
          bcnt <= bcnt + 32'h1;
          // synchroniser lag puts the pin sample two cycles earlier
          if (bcnt == 32'(BOOT_SAMPLE - 2)) begin
            o_strap_value    <= strap_s;
            o_straps_latched <= 1'b1;
            state <= (strap_s == STRAP_GOOD) ? BOOT_RUN : BOOT_FAULT;
          end
        end
        BOOT_RUN:   state <= BOOT_RUN;
        BOOT_FAULT: state <= BOOT_FAULT;
        default:    state <= BOOT_FAULT;
      endcase
    end
  end

  // function enables
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_wifi_active <= 1'b0;
      o_bt_active   <= 1'b0;
      o_fault       <= 1'b0;
    end else begin
      o_wifi_active <= run && wifi_s;
      o_bt_active   <= run && bt_s;
      o_fault       <= (state == BOOT_FAULT);
    end
  end

  // audio bit clock; a mode switch mid-frame is not glitch free
  logic [15:0] mdiv;
  logic        mrise, mfall, srise, sfall, pclk_d, prise, pfall;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mdiv      <= 16'h0;
      o_pcm_clk <= 1'b0;
      pclk_d    <= 1'b0;
    end else begin
      pclk_d <= pclk_s;
      if (mdiv == 16'(PCM_HALF - 1)) begin
        mdiv      <= 16'h0;
        o_pcm_clk <= ~o_pcm_clk;
      end else begin
        mdiv <= mdiv + 16'h1;
      end
    end
  end
  assign mrise = (mdiv == 16'(PCM_HALF - 1)) && !o_pcm_clk;
  assign mfall = (mdiv == 16'(PCM_HALF - 1)) && o_pcm_clk;
  assign srise = pclk_s && !pclk_d;
  assign sfall = !pclk_s && pclk_d;
  assign prise = o_bt_active && (i_pcm_master ? mrise : srise);
  assign pfall = o_bt_active && (i_pcm_master ? mfall : sfall);

  // audio framing
  logic [SW-1:0]    slot, next_slot;
  logic             frame_pend;
  logic [PCM_W-1:0] tx_sh, rx_sh;
  logic             in_data;
  always_comb begin
    next_slot = slot + SW'(1);
    if (frame_pend) begin
      next_slot = SW'(1);
    end else if (slot == SW'(SLOTS - 1)) begin
      next_slot = i_pcm_master ? SW'(0) : slot;
    end
  end
  assign in_data = (slot != SW'(0)) && (slot <= SW'(PCM_W));

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      slot          <= SW'(SLOTS - 1);
      o_pcm_sync    <= 1'b0;
      o_pcm_dout    <= 1'b1;
      tx_sh         <= '0;
      o_pcm_tx_take <= 1'b0;
    end else begin
      o_pcm_tx_take <= 1'b0;
      if (prise) begin
        slot <= next_slot;
        o_pcm_sync <= i_pcm_master && (slot == SW'(SLOTS - 1));
        if (next_slot == SW'(1)) begin
          o_pcm_dout    <= i_pcm_tx_word[PCM_W-1];
          tx_sh         <= i_pcm_tx_word << 1;
          o_pcm_tx_take <= 1'b1;
        end else if (next_slot != SW'(0) && next_slot <= SW'(PCM_W)) begin
          o_pcm_dout <= tx_sh[PCM_W-1];
          tx_sh      <= tx_sh << 1;
        end else begin
          o_pcm_dout <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      frame_pend     <= 1'b0;
      rx_sh          <= '0;
      o_pcm_rx_word  <= '0;
      o_pcm_rx_valid <= 1'b0;
    end else begin
      o_pcm_rx_valid <= 1'b0;
      if (pfall) begin
        frame_pend <= i_pcm_master ? o_pcm_sync : psync_s;
        if (in_data) begin
          rx_sh <= {rx_sh[PCM_W-2:0], din_s};
          if (slot == SW'(PCM_W)) begin
            o_pcm_rx_word  <= {rx_sh[PCM_W-2:0], din_s};
            o_pcm_rx_valid <= 1'b1;
          end
        end
      end
    end
  end

  assign o_pcm_clk_oe  = o_bt_active && i_pcm_master;
  assign o_pcm_sync_oe = o_bt_active && i_pcm_master;
  assign o_pcm_dout_oe = o_bt_active;

  // uarts: channel 0 hci, channel 1 coexistence, 8N1
  logic [1:0][7:0] u_tdata;
  logic [1:0]      u_tvalid, u_ready, u_txd, u_cts, u_rxd, u_en;
  rmha_byte_type   u_rx [2];
  assign u_tdata  = {i_coex_tx_data, i_hci_tx_data};
  assign u_tvalid = {i_coex_tx_valid, i_hci_tx_valid};
  assign u_rxd    = {crx_s, hrx_s};
  assign u_cts    = {1'b1, !cts_n_s};
  assign u_en     = {run, o_bt_active};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_uart
      logic [9:0]  tsh;
      logic [3:0]  tbit, rbit;
      logic [15:0] tcnt, rcnt;
      logic        tbusy, rbusy;
      logic [7:0]  rsh;
      assign u_ready[ch] = u_en[ch] && !tbusy && u_cts[ch];
      assign u_txd[ch]   = tbusy ? tsh[0] : 1'b1;
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          tbusy <= 1'b0;
          tsh   <= 10'h3FF;
          tbit  <= 4'h0;
          tcnt  <= 16'h0;
        end else if (!tbusy) begin
          if (u_tvalid[ch] && u_ready[ch]) begin
            tbusy <= 1'b1;
            tsh   <= {1'b1, u_tdata[ch], 1'b0};
            tbit  <= 4'h0;
            tcnt  <= 16'h0;
          end
        end else if (tcnt == 16'(UART_DIV - 1)) begin
          tcnt <= 16'h0;
          tsh  <= {1'b1, tsh[9:1]};
          tbit <= tbit + 4'h1;
          if (tbit == 4'h9) begin
            tbusy <= 1'b0;
          end
        end else begin
          tcnt <= tcnt + 16'h1;
        end
      end
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          rbusy      <= 1'b0;
          rbit       <= 4'h0;
          rcnt       <= 16'h0;
          rsh        <= 8'h0;
          u_rx[ch]   <= '0;
        end else begin
          u_rx[ch].valid <= 1'b0;
          if (!rbusy) begin
            rbit <= 4'h0;
            rcnt <= 16'(UART_DIV / 2);
            if (!u_rxd[ch] && u_en[ch]) begin
              rbusy <= 1'b1;
            end
          end else if (rcnt == 16'(UART_DIV - 1)) begin
            rcnt <= 16'h0;
            rbit <= rbit + 4'h1;
            if (rbit == 4'h0 && u_rxd[ch]) begin
              rbusy <= 1'b0;
            end else if (rbit == 4'h9) begin
              rbusy <= 1'b0;
              // a framing error drops the byte
              if (u_rxd[ch]) begin
                u_rx[ch].data  <= rsh;
                u_rx[ch].valid <= 1'b1;
              end
            end else if (rbit != 4'h0) begin
              rsh <= {u_rxd[ch], rsh[7:1]};
            end
          end else begin
            rcnt <= rcnt + 16'h1;
          end
        end
      end
    end
  endgenerate

  assign o_hci_tx_ready  = u_ready[0];
  assign o_coex_tx_ready = u_ready[1];
  assign o_hci_rx        = u_rx[0];
  assign o_coex_rx       = u_rx[1];

  // strapped outputs stay released until boot passes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_hci_serial_tx         <= 1'b1;
      o_coexist_serial_tx     <= 1'b1;
      o_hci_request_to_send_n <= 1'b1;
      o_host_wakeup_out       <= 1'b0;
    end else begin
      o_hci_serial_tx         <= u_txd[0];
      o_coexist_serial_tx     <= u_txd[1];
      o_hci_request_to_send_n <= !(o_bt_active && !i_hci_rx_hold);
      o_host_wakeup_out       <= run && i_wake_request;
    end
  end
  assign o_hci_serial_tx_oe       = run;
  assign o_hci_request_to_send_oe = run;
  assign o_coexist_serial_tx_oe   = run;
  assign o_host_wakeup_out_oe     = run;

  // sleep clock tick
  logic [15:0] sdiv;
  logic        lp_d, int_tick;
  assign int_tick = (sdiv == 16'(SLEEP_DIV - 1));
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sdiv         <= 16'h0;
      lp_d         <= 1'b0;
      o_sleep_tick <= 1'b0;
    end else begin
      lp_d <= lpclk_s;
      sdiv <= int_tick ? 16'h0 : sdiv + 16'h1;
      o_sleep_tick <= i_sleep_mode &&
                      (i_use_ext_sleep_clk ? (lpclk_s && !lp_d) : int_tick);
    end
  end

  a_strap_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    $past(o_straps_latched) |-> $stable(o_strap_value) && o_straps_latched)
    else $error("strap value changed after latch");

  a_boot_window: assert property (@(posedge i_clock) disable iff (i_rst)
    (state == BOOT_WAIT) |-> bcnt < 32'(BOOT_SAMPLE - 1))
    else $error("strap sample past window");

  a_fault_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    o_fault |-> !o_wifi_active && !o_bt_active && !o_hci_serial_tx_oe)
    else $error("functions live in fault state");

  a_wifi_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    !wifi_s ##1 !wifi_s |-> !o_wifi_active)
    else $error("wifi active with enable low");

  a_bt_enable: assert property (@(posedge i_clock) disable iff (i_rst)
    (run && bt_s) ##1 (run && bt_s) |-> o_bt_active)
    else $error("bluetooth not enabled");

  a_dout_rise: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(o_pcm_dout) |-> $past(prise))
    else $error("audio out changed off a rising edge");

  a_sync_rise: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(o_pcm_sync) |-> $past(prise) &&
                             ($past(i_pcm_master) || !o_pcm_sync))
    else $error("frame sync changed off a rising edge");

  a_rx_fall: assert property (@(posedge i_clock) disable iff (i_rst)
    o_pcm_rx_valid |-> $past(pfall) && $past(slot) == SW'(PCM_W))
    else $error("audio word not taken on falling edge");

  a_cts_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    cts_n_s && !g_uart[0].tbusy |=> !g_uart[0].tbusy)
    else $error("hci transmit offered without clear to send");

  a_wake_boot: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_host_wakeup_out) |-> $past(i_wake_request) && run)
    else $error("wake raised without request");
endmodule
`default_nettype wire

// *** core/rmha_pkg.sv ***
package rmha_pkg;
  localparam int CLK_HZ         = 100_000_000;
  localparam int BOOT_WINDOW_MS = 100;
  // latest sample point, rounded down
  localparam int BOOT_CYC       = CLK_HZ / 1000 * BOOT_WINDOW_MS;
  localparam int HCI_MAX_BAUD   = 3_200_000;
  // divisor rounded up keeps the rate at or below the ceiling
  localparam int BAUD_DIV       = (CLK_HZ + HCI_MAX_BAUD - 1) / HCI_MAX_BAUD;
  localparam int PCM_MAX_HZ     = 2_048_000;
  localparam int PCM_MIN_HZ     = 64_000;
  localparam int PCM_HALF_MIN   = (CLK_HZ + 2 * PCM_MAX_HZ - 1)
                                  / (2 * PCM_MAX_HZ);
  localparam int PCM_HALF_MAX   = CLK_HZ / (2 * PCM_MIN_HZ);
  localparam int PCM_HALF_DEF   = 50;
  localparam int PCM_WORD       = 16;
  localparam int PCM_SLOTS      = 32;
  localparam int SLEEP_HZ       = 32_768;
  localparam int SLEEP_DIV      = CLK_HZ / SLEEP_HZ;

  typedef enum logic [3:0] {
    BOOT_IDLE  = 4'h1,
    BOOT_WAIT  = 4'h2,
    BOOT_RUN   = 4'h4,
    BOOT_FAULT = 4'h8
  } rmha_boot_type;

  typedef struct packed {
    logic pcm_dout;
    logic pcm_sync;
    logic host_wake;
    logic hci_rts;
    logic hci_tx;
    logic coex_tx;
  } rmha_strap_type;

  localparam rmha_strap_type STRAP_GOOD  = 6'h27;
  localparam rmha_strap_type STRAP_RESET = 6'h00;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } rmha_byte_type;
endpackage

// *** verification/rmha_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmha_host_model
  import rmha_pkg::*;
#(
  parameter int HALF_NS = 280,
  parameter int DIV     = 32
) (
  input  wire logic           i_clock,
  input  wire logic           i_latched,
  input  wire rmha_strap_type i_bad,
  input  wire logic           i_run,
  input  wire logic [15:0]    i_word,
  input  wire logic           i_stop,
  input  wire logic           i_clk,
  input  wire logic           i_clk_oe,
  input  wire logic           i_sync,
  input  wire logic           i_sync_oe,
  input  wire logic           i_dout,
  input  wire logic           i_master,
  output rmha_strap_type      o_strap,
  output logic                o_clk,
  output logic                o_sync,
  output logic                o_din,
  output logic                o_cts_n,
  output logic [1:0]          o_rx,
  output logic [15:0]         o_cap
);
  logic clk = 1'b0;
  logic sync = 1'b0;
  logic din = 1'b0;
  assign o_strap = STRAP_GOOD ^ i_bad;
  assign o_clk = i_clk_oe ? i_clk : i_latched & clk;
  assign o_sync = i_sync_oe ? i_sync : i_latched & sync;
  assign o_din = i_master ? i_dout : din;
  assign o_cts_n = i_stop;
  initial o_rx = 2'h3;
  // slave frames, clock still between runs
  initial begin
    forever begin
      @(negedge i_clock);
      while (i_run) begin
        for (int s = 0; s < 32; s++) begin
          #HALF_NS;
          clk = 1'b1;
          sync = s == 0;
          din = (s > 0 && s < 17) ? i_word[16-s] : ~din;
          #HALF_NS;
          clk = 1'b0;
          if (s > 0 && s < 17) o_cap[16-s] = i_dout;
        end
      end
    end
  end
  task automatic send(input int p, input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int b = 0; b < 10; b++) begin
      o_rx[p] = f[b];
      repeat (DIV) @(negedge i_clock);
    end
  endtask
endmodule
`default_nettype wire

// *** verification/rmha_link_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmha_link_bench
  import rmha_pkg::*;
;
  localparam int BS = 20;
  localparam int PH = 25;
  localparam int UD = 32;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wen = 1'b0, ben = 1'b0, mst = 1'b0, hold = 1'b0, srun = 1'b0;
  logic hval = 1'b0, cval = 1'b0, stop = 1'b0, wake = 1'b0;
  logic lpc = 1'b0, ext = 1'b0, slp = 1'b0;
  logic [7:0] hdat = 8'h00, cdat = 8'h00;
  logic [15:0] txw = 16'h0000, hword = 16'h0000, rxw, cap;
  rmha_strap_type mask = STRAP_RESET, strap, sval;
  rmha_byte_type hrx, crx;
  logic [1:0] urx;
  logic wact, bact, flt, lat, pclk, psync, pdin, pco, pcoe, pso, psoe;
  logic pdo, rxv, hrdy, htx, rtsn, ctsn, crdy, ctx, hw, hwo, tick;
  logic doe, htoe, rtoe, ctoe, take;
  int n_errors = 0, tests_run = 0, ticks = 0, takes = 0;

  rmha_link #(.BOOT_SAMPLE(BS), .PCM_HALF(PH), .UART_DIV(UD)) i_rmha_link (
    .i_clock(clk), .i_rst(rst), .i_wifi_function_enable(wen),
    .i_bluetooth_enable(ben), .i_strap_level(strap), .o_wifi_active(wact),
    .o_bt_active(bact), .o_fault(flt), .o_straps_latched(lat),
    .o_strap_value(sval), .i_pcm_master(mst), .i_pcm_clk(pclk),
    .o_pcm_clk(pco), .o_pcm_clk_oe(pcoe), .i_pcm_sync(psync),
    .o_pcm_sync(pso), .o_pcm_sync_oe(psoe), .i_pcm_din(pdin),
    .o_pcm_dout(pdo), .o_pcm_dout_oe(doe), .i_pcm_tx_word(txw),
    .o_pcm_tx_take(take), .o_pcm_rx_word(rxw), .o_pcm_rx_valid(rxv),
    .i_hci_tx_data(hdat), .i_hci_tx_valid(hval), .o_hci_tx_ready(hrdy),
    .o_hci_rx(hrx), .i_hci_rx_hold(hold), .o_hci_serial_tx(htx),
    .o_hci_serial_tx_oe(htoe), .i_hci_serial_rx(urx[0]),
    .o_hci_request_to_send_n(rtsn), .o_hci_request_to_send_oe(rtoe),
    .i_hci_clear_to_send_n(ctsn), .i_coex_tx_data(cdat),
    .i_coex_tx_valid(cval), .o_coex_tx_ready(crdy), .o_coex_rx(crx),
    .o_coexist_serial_tx(ctx), .o_coexist_serial_tx_oe(ctoe),
    .i_coexist_serial_rx(urx[1]), .i_wake_request(wake),
    .o_host_wakeup_out(hw), .o_host_wakeup_out_oe(hwo),
    .i_low_power_clock_in(lpc), .i_use_ext_sleep_clk(ext),
    .i_sleep_mode(slp), .o_sleep_tick(tick)
  );
  rmha_host_model i_rmha_host_model (
    .i_clock(clk), .i_latched(lat), .i_bad(mask), .i_run(srun),
    .i_word(hword), .i_stop(stop), .i_clk(pco), .i_clk_oe(pcoe),
    .i_sync(pso), .i_sync_oe(psoe), .i_dout(pdo), .i_master(mst),
    .o_strap(strap), .o_clk(pclk), .o_sync(psync), .o_din(pdin),
    .o_cts_n(ctsn), .o_rx(urx), .o_cap(cap)
  );

  initial forever #5 clk = ~clk;
  always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;
  always @(posedge clk) if (take === 1'b1) takes <= takes + 1;

  task automatic give_verdict;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic boot(input logic w, input logic b, input rmha_strap_type m);
    int n;
    {wen, ben, mask, rst} = {2'b00, m, 1'b1};
    cyc(20);
    rst = 1'b0;
    cyc(3);
    {wen, ben} = {w, b};
    for (n = 0; lat !== 1'b1 && n < BS + 50; n++) cyc(1);
    chk(n >= BS && n <= BS + 2, "boot sample time");
    cyc(2);
    chk(sval === (STRAP_GOOD ^ m), "strap value");
    chk(flt === (m != 6'h00), "fault state");
  endtask
  task automatic tx(input int p, input logic [7:0] d);
    int n;
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    if (p == 0) {hdat, hval} = {d, 1'b1};
    else {cdat, cval} = {d, 1'b1};
    for (n = 0; (p ? crdy : hrdy) !== 1'b1 && n < 2000; n++) cyc(1);
    chk(n < 2000, "tx ready");
    cyc(1);
    {hval, cval} = 2'b00;
    for (n = 0; n < 4 && (p ? ctx : htx) !== 1'b0; n++) cyc(1);
    cyc(UD / 2);
    for (int b = 0; b < 10; b++) begin
      chk((p ? ctx : htx) === f[b], "tx bit");
      cyc(UD);
    end
  endtask
  task automatic rx(input int p, input logic [7:0] d);
    logic got;
    got = 1'b0;
    fork
      i_rmha_host_model.send(p, d);
      repeat (12 * UD) begin
        @(negedge clk);
        if ((p ? crx : hrx) === {d, 1'b1}) got = 1'b1;
      end
    join
    chk(got, "rx byte");
  endtask
  task automatic pcm_wait(input int k);
    for (int n = 0; k > 0 && n < 8000; n++) begin
      cyc(1);
      if (rxv === 1'b1) k--;
    end
    chk(k == 0, "pcm word count");
  endtask

  // span over two and a half times the expected run
  initial begin
    cyc(80000);
    n_errors++;
    $display("mismatch at %0t: watchdog", $time);
    give_verdict;
  end

  initial begin
    logic [7:0] d;
    logic p;
    int n;
    void'($urandom(47943));
    boot(1'b0, 1'b1, 6'($urandom_range(63, 1)));
    chk(wact === 1'b0 && bact === 1'b0, "dead device");
    chk({doe, htoe, rtoe, ctoe, hwo} === 5'h00, "dead released");
    boot(1'b1, 1'b0, STRAP_RESET);
    chk(wact === 1'b1 && bact === 1'b0, "wifi only");
    {wen, ben, mask} = {2'b01, 6'($urandom_range(63, 1))};
    cyc(6);
    chk(wact === 1'b0 && bact === 1'b1, "bt only");
    {wen, ben} = 2'b00;
    cyc(6);
    chk(wact === 1'b0 && bact === 1'b0, "both off");
    {wen, ben} = 2'b11;
    cyc(BS + 10);
    chk(sval === STRAP_GOOD && lat === 1'b1, "no resample");
    chk(flt === 1'b0 && wact === 1'b1 && bact === 1'b1, "run");
    chk({doe, htoe, rtoe, ctoe} === 4'hF, "pins driven");
    mask = STRAP_RESET;
    wake = 1'b1;
    cyc(3);
    chk(hw === 1'b1 && hwo === 1'b1, "wake high");
    wake = 1'b0;
    cyc(3);
    chk(hw === 1'b0, "wake low");
    hold = 1'b1;
    cyc(6);
    chk(rtsn === 1'b1, "rts withdrawn");
    hold = 1'b0;
    cyc(6);
    chk(rtsn === 1'b0, "rts given");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      tx(0, d);
      tx(1, ~d);
      rx(0, d);
      rx(1, ~d);
    end
    d = 8'($urandom);
    fork
      tx(0, d);
      begin
        cyc(UD * 3);
        stop = 1'b1;
      end
    join
    {hdat, hval} = {~d, 1'b1};
    n = 0;
    repeat (20 * UD) begin
      cyc(1);
      n += (htx !== 1'b1);
    end
    chk(n == 0, "held by cts");
    stop = 1'b0;
    tx(0, ~d);
    txw = 16'($urandom);
    takes = 0;
    mst = 1'b1;
    pcm_wait(2);
    chk(takes == 2, "tx word takes");
    chk(rxw === txw, "master loopback");
    chk(pcoe === 1'b1 && psoe === 1'b1, "master drives");
    n = 0;
    p = pco;
    repeat (40 * PH) begin
      cyc(1);
      n += (pco === 1'b1) && (p === 1'b0);
      p = pco;
    end
    chk(n == 20 && PH >= PCM_HALF_MIN && PH <= PCM_HALF_MAX, "rate");
    mst = 1'b0;
    hword = 16'($urandom);
    srun = 1'b1;
    pcm_wait(3);
    srun = 1'b0;
    cyc(2000);
    chk(rxw === hword, "slave word in");
    chk(cap === txw, "slave word out");
    chk(pcoe === 1'b0 && psoe === 1'b0, "slave released");
    slp = 1'b1;
    cyc(SLEEP_DIV + 20);
    ticks = 0;
    cyc(2 * SLEEP_DIV);
    chk(ticks == 2, "internal ticks");
    slp = 1'b0;
    cyc(20);
    ticks = 0;
    cyc(SLEEP_DIV + 20);
    chk(ticks == 0, "awake no ticks");
    {ext, slp} = 2'b11;
    cyc(20);
    ticks = 0;
    repeat (5) begin
      #40 lpc = 1'b1;
      #40 lpc = 1'b0;
    end
    cyc(10);
    chk(ticks == 5, "external ticks");
    give_verdict;
  end
endmodule
`default_nettype wire
